/* hw/pmc_defs.svh */
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

// ------------------------------------------------------------
// request encodings on the firmware mode port
// ------------------------------------------------------------
`define PMC_REQ_ACTIVE 2'h0
`define PMC_REQ_ALT 2'h1
`define PMC_REQ_SLEEP 2'h2
`define PMC_REQ_HIB 2'h3

// ------------------------------------------------------------
// wake source bit positions (sleep-capable sources)
// ------------------------------------------------------------
`define PMC_WK_COMP 0
`define PMC_WK_PIN 1
`define PMC_WK_I2C 2
`define PMC_WK_RTC 3
`define PMC_WK_TIMEWHEEL 4
`define PMC_WK_LVD 5
`define PMC_WK_NUM 6

// ------------------------------------------------------------
// timing: resume limits and clock rate
// ------------------------------------------------------------
`define PMC_CLK_MHZ 250
`define PMC_SLEEP_RESUME_US 15
`define PMC_HIB_RESUME_US 100
// longest times round down; both divide evenly here
`define PMC_SLEEP_RESUME_CYC (`PMC_SLEEP_RESUME_US * `PMC_CLK_MHZ)
`define PMC_HIB_RESUME_CYC (`PMC_HIB_RESUME_US * `PMC_CLK_MHZ)

// ------------------------------------------------------------
// subsystem template, cpu sits in bit 0
// ------------------------------------------------------------
`define PMC_SUB_NUM 8
`define PMC_SUB_CPU 0
`define PMC_BUZZ_DIV 16

// ------------------------------------------------------------
// bit positions in the registered power control word
// ------------------------------------------------------------
`define PMC_CTL_NUM 8
`define PMC_CTL_SYSCLK 7
`define PMC_CTL_LOSC 6
`define PMC_CTL_KHZ 5
`define PMC_CTL_STMR 4
`define PMC_CTL_DREG 3
`define PMC_CTL_AREG 2
`define PMC_CTL_HREG 1
`define PMC_CTL_SREG 0

`endif

/* hw/pmc_pkg.sv */
package pmc_pkg;
    // global power mode, gray along active-alt-sleep-hib
    typedef enum logic [1:0] {
        PMC_ACTIVE = 2'h0,
        PMC_ALT = 2'h1,
        PMC_SLEEP = 2'h3,
        PMC_HIB = 2'h2
    } pmc_mode_e;
endpackage : pmc_pkg

/* hw/pmc_resume_timer.sv */
`timescale 1ns/1ns
`include "pmc_defs.svh"

// counts down a resume interval and pulses done once at its end
module pmc_resume_timer #(
    parameter int CNT_W = 15
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // control
    input wire logic load,
    input wire logic [CNT_W-1:0] load_val,
    // status
    output logic busy,
    output logic done
);
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic done_ff, nxt_done;

    // ----------------------------------------
    // countdown
    // ----------------------------------------
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_done = 1'b0;
        if (load) begin
            nxt_cnt = load_val;
        end else if (cnt_ff != '0) begin
            nxt_cnt = cnt_ff - CNT_W'(1);
            nxt_done = (cnt_ff == CNT_W'(1));
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cnt_ff <= '0;
            done_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            done_ff <= nxt_done;
        end
    end

    assign busy = (cnt_ff != '0);
    assign done = done_ff;
endmodule : pmc_resume_timer

/* hw/pmc_power_mode_controller.sv */
`timescale 1ns/1ns
`include "pmc_defs.svh"

module pmc_power_mode_controller
    import pmc_pkg::*;
#(
    parameter int SUB_NUM = `PMC_SUB_NUM,
    parameter int SLEEP_RESUME_CYC = `PMC_SLEEP_RESUME_CYC,
    parameter int HIB_RESUME_CYC = `PMC_HIB_RESUME_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // firmware mode request, taken when req_done pulses
    input wire logic req_done,
    input wire logic req_valid_code,
    input wire logic [1:0] req_mode,
    // subsystem templates
    input wire logic [SUB_NUM-1:0] active_template,
    input wire logic [SUB_NUM-1:0] alt_template,
    input wire logic ext_regulation,
    // wakeup sources
    input wire logic irq_any,
    input wire logic [`PMC_WK_NUM-1:0] wake_src,
    // status and power controls
    output pmc_pkg::pmc_mode_e mode,
    output logic resuming,
    output logic [SUB_NUM-1:0] sub_enable,
    output logic cpu_enable,
    output logic sys_clk_enable,
    output logic low_speed_oscillator_enable,
    output logic khz_crystal_oscillator_enable,
    output logic sleep_timer_enable,
    output logic dig_reg_enable,
    output logic ana_reg_enable,
    output logic hib_reg_enable,
    output logic sleep_reg_enable
);
    import pmc_pkg::*;

    localparam int CNT_W = $clog2(HIB_RESUME_CYC + 1);

    // ----------------------------------------
    // pin-side wake sources, two-flop synchronised
    // ----------------------------------------
    logic [`PMC_WK_NUM-1:0] wk_s1_ff, wk_s2_ff;
    logic irq_s1_ff, irq_s2_ff;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wk_s1_ff <= '0;
            wk_s2_ff <= '0;
            irq_s1_ff <= 1'b0;
            irq_s2_ff <= 1'b0;
        end else begin
            wk_s1_ff <= wake_src;
            wk_s2_ff <= wk_s1_ff;
            irq_s1_ff <= irq_any;
            irq_s2_ff <= irq_s1_ff;
        end
    end

    // which sources may wake the given mode
    function automatic logic wake_hit(input pmc_mode_e m, input logic [`PMC_WK_NUM-1:0] w, input logic irq);
        unique case (m)
            PMC_ACTIVE: wake_hit = irq;
            PMC_ALT: wake_hit = irq;
            PMC_SLEEP: wake_hit = |w;
            PMC_HIB: wake_hit = w[`PMC_WK_PIN];
        endcase
    endfunction : wake_hit

    // ----------------------------------------
    // mode state and cpu force
    // ----------------------------------------
    pmc_mode_e mode_ff, nxt_mode;
    logic cpu_force_ff, nxt_cpu_force;
    logic tmr_load;
    logic [CNT_W-1:0] tmr_val;
    logic tmr_busy;
    logic tmr_done;
    logic wake;

    assign wake = wake_hit(mode_ff, wk_s2_ff, irq_s2_ff);

    // mode transitions; wakeup beats a request in the same cycle
    always_comb begin
        nxt_mode = mode_ff;
        nxt_cpu_force = cpu_force_ff;
        tmr_load = 1'b0;
        tmr_val = '0;
        if (wake) begin
            if (mode_ff == PMC_SLEEP) begin
                tmr_load = 1'b1;
                tmr_val = CNT_W'(SLEEP_RESUME_CYC);
            end else if (mode_ff == PMC_HIB) begin
                tmr_load = 1'b1;
                tmr_val = CNT_W'(HIB_RESUME_CYC);
            end
            if (mode_ff != PMC_ACTIVE) begin
                nxt_mode = PMC_ACTIVE;
            end
            nxt_cpu_force = 1'b1;
        end else if (req_done && req_valid_code && !tmr_busy) begin
            unique case (req_mode)
                `PMC_REQ_ACTIVE: nxt_mode = PMC_ACTIVE;
                `PMC_REQ_ALT: nxt_mode = PMC_ALT;
                `PMC_REQ_SLEEP: nxt_mode = PMC_SLEEP;
                `PMC_REQ_HIB: nxt_mode = PMC_HIB;
            endcase
            nxt_cpu_force = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mode_ff <= PMC_ACTIVE;
            cpu_force_ff <= 1'b1;
        end else begin
            mode_ff <= nxt_mode;
            cpu_force_ff <= nxt_cpu_force;
        end
    end

    // resume window after leaving a low-power mode
    pmc_resume_timer #(
        .CNT_W(CNT_W)
    ) u_resume (
        .ref_clk(ref_clk),
        .srst(srst),
        .load(tmr_load),
        .load_val(tmr_val),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    // ----------------------------------------
    // regulator buzz divider for sleep
    // ----------------------------------------
    logic [$clog2(`PMC_BUZZ_DIV)-1:0] buzz_ff, nxt_buzz;

    // one-cycle enable pulses keep a single clock domain
    always_comb begin
        nxt_buzz = (mode_ff == PMC_SLEEP) ? buzz_ff + 1'b1 : '0;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            buzz_ff <= '0;
        end else begin
            buzz_ff <= nxt_buzz;
        end
    end

    // ----------------------------------------
    // power controls, registered; sub_enable, sys_clk_enable and the dig/ana regulator enables then combine with tmr_busy
    // ----------------------------------------
    logic [SUB_NUM-1:0] sub_ff, nxt_sub;
    logic [`PMC_CTL_NUM-1:0] ctl_ff, nxt_ctl;

    always_comb begin
        nxt_sub = '0;
        nxt_ctl = '0;
        unique case (mode_ff)
            PMC_ACTIVE: begin
                nxt_sub = active_template;
                nxt_ctl = {1'b1, 1'b1, 1'b1, 1'b1, !ext_regulation, !ext_regulation, 1'b1, 1'b0};
            end
            PMC_ALT: begin
                nxt_sub = alt_template;
                nxt_ctl = {1'b1, 1'b1, 1'b1, 1'b1, !ext_regulation, !ext_regulation, 1'b1, 1'b0};
            end
            PMC_SLEEP: begin
                nxt_sub = '0;
                nxt_ctl = {1'b0, 1'b1, 1'b1, 1'b1, !ext_regulation && (buzz_ff == '0),
                           !ext_regulation && (buzz_ff == '0), 1'b1, 1'b1};
            end
            PMC_HIB: begin
                nxt_sub = '0;
                nxt_ctl = {1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
            end
        endcase
        // cpu back on after any wakeup whatever the template
        if (cpu_force_ff && (mode_ff == PMC_ACTIVE || mode_ff == PMC_ALT)) begin
            nxt_sub[`PMC_SUB_CPU] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sub_ff <= '0;
            ctl_ff <= '0;
        end else begin
            sub_ff <= nxt_sub;
            ctl_ff <= nxt_ctl;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign mode = mode_ff;
    assign resuming = tmr_busy;
    assign sub_enable = tmr_busy ? '0 : sub_ff;
    assign cpu_enable = sub_enable[`PMC_SUB_CPU];
    assign sys_clk_enable = ctl_ff[`PMC_CTL_SYSCLK] && !tmr_busy;
    assign low_speed_oscillator_enable = ctl_ff[`PMC_CTL_LOSC];
    assign khz_crystal_oscillator_enable = ctl_ff[`PMC_CTL_KHZ];
    assign sleep_timer_enable = ctl_ff[`PMC_CTL_STMR];
    assign dig_reg_enable = ctl_ff[`PMC_CTL_DREG] || (tmr_busy && !ext_regulation);
    assign ana_reg_enable = ctl_ff[`PMC_CTL_AREG] || (tmr_busy && !ext_regulation);
    assign hib_reg_enable = ctl_ff[`PMC_CTL_HREG];
    assign sleep_reg_enable = ctl_ff[`PMC_CTL_SREG];

    // tmr_done marks the end of the resume window; kept for tracing
    logic unused_done;
    assign unused_done = tmr_done;
endmodule : pmc_power_mode_controller

/* test/pmc_power_mode_controller_asserts.sv */
`timescale 1ns/1ns
`include "pmc_defs.svh"

module pmc_power_mode_controller_asserts
    import pmc_pkg::*;
#(
    parameter int SUB_NUM = 8,
    parameter int SLEEP_RESUME_CYC = 10,
    parameter int HIB_RESUME_CYC = 20
) (
    // clock, reset, requests and wakes
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic req_done,
    input wire logic req_valid_code,
    input wire logic [1:0] req_mode,
    input wire logic ext_regulation,
    input wire logic irq_any,
    input wire logic [`PMC_WK_NUM-1:0] wake_src,
    // watched outputs
    input wire pmc_pkg::pmc_mode_e mode,
    input wire logic resuming,
    input wire logic [SUB_NUM-1:0] sub_enable,
    input wire logic sys_clk_enable,
    input wire logic low_speed_oscillator_enable,
    input wire logic khz_crystal_oscillator_enable,
    input wire logic sleep_timer_enable,
    input wire logic dig_reg_enable,
    input wire logic ana_reg_enable,
    input wire logic hib_reg_enable
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    logic [2:0] wk_hist_ff, nxt_wk_hist;
    logic [15:0] res_cnt_ff, nxt_res_cnt;
    logic quiet;
    logic from_slp_ff, nxt_from_slp;
    // wakes pass a two-flop sync, so a request is only judged after three calm cycles
    always_comb begin
        nxt_wk_hist = srst ? 3'h0 : {wk_hist_ff[1:0], (|wake_src) | irq_any};
        nxt_res_cnt = (resuming && !srst) ? res_cnt_ff + 16'h1 : 16'h0;
        quiet = (wk_hist_ff == 3'h0) && !(|wake_src) && !irq_any;
        // remembers which low-power mode the current resume window left
        nxt_from_slp = srst ? 1'b0 : (mode == PMC_SLEEP) ? 1'b1 : (mode == PMC_HIB) ? 1'b0 : from_slp_ff;
    end
    always_ff @(posedge ref_clk) begin
        wk_hist_ff <= nxt_wk_hist;
        from_slp_ff <= nxt_from_slp;
        res_cnt_ff <= nxt_res_cnt;
    end
    function automatic pmc_mode_e map_f(input logic [1:0] m);
        return (m == 2'h2) ? PMC_SLEEP : (m == 2'h3) ? PMC_HIB : pmc_mode_e'(m);
    endfunction : map_f
    sequence take_s;
        req_done && req_valid_code && !resuming && quiet;
    endsequence
    sequence sleep3_s;
        (mode == PMC_SLEEP) [*3];
    endsequence
    req_take_a: assert property (take_s |=> mode == map_f($past(req_mode)))
        else $error("accepted request gave wrong mode");
    bad_code_a: assert property (req_done && !req_valid_code && !resuming && quiet |=> $stable(mode))
        else $error("undefined code changed mode");
    sleep_gate_a: assert property (mode == PMC_SLEEP && $past(mode) == PMC_SLEEP |-> sub_enable == '0
        && !sys_clk_enable && sleep_timer_enable && (low_speed_oscillator_enable || khz_crystal_oscillator_enable))
        else $error("sleep controls wrong");
    hib_regs_a: assert property (mode == PMC_HIB && $past(mode) == PMC_HIB |-> hib_reg_enable && sub_enable == '0
        && !dig_reg_enable && !ana_reg_enable && !sys_clk_enable && !low_speed_oscillator_enable)
        else $error("hibernate controls wrong");
    buzz_off_a: assert property (sleep3_s ##0 dig_reg_enable ##1 mode == PMC_SLEEP |-> !dig_reg_enable)
        else $error("sleep regulator not buzzed");
    buzz_on_a: assert property (sleep3_s ##0 !ext_regulation |-> ##[0:16] (dig_reg_enable || mode != PMC_SLEEP))
        else $error("sleep regulator never pulsed");
    ext_reg_a: assert property (ext_regulation && $past(ext_regulation) && $past(ext_regulation, 2)
        |-> !dig_reg_enable && !ana_reg_enable)
        else $error("core regulator on under external regulation");
    sleep_wake_a: assert property (mode == PMC_SLEEP && |wake_src |-> ##[1:4] mode == PMC_ACTIVE)
        else $error("sleep wake not taken");
    resume_win_a: assert property (resuming |-> res_cnt_ff < HIB_RESUME_CYC && sub_enable == '0
        && mode == PMC_ACTIVE)
        else $error("resume window wrong");
    sleep_res_a: assert property (resuming && from_slp_ff |-> res_cnt_ff < SLEEP_RESUME_CYC)
        else $error("sleep resume window too long");
endmodule : pmc_power_mode_controller_asserts

/* test/pmc_power_mode_controller_tb_top.sv */
`timescale 1ns/1ns
`include "pmc_defs.svh"

module pmc_power_mode_controller_tb_top;
    import pmc_pkg::*;
    logic ref_clk = 1'b0, srst = 1'b1, req_done = 1'b0, req_valid_code = 1'b0, ext_regulation = 1'b0, irq_any = 1'b0;
    logic [1:0] req_mode = 2'h0;
    logic [7:0] act_t = 8'h5a, alt_t = 8'h3c, sub_enable;
    logic [5:0] wake_src = 6'h0;
    pmc_mode_e mode;
    logic resuming, cpu_en, sys_clk, lo_osc, khz_osc, slp_tmr, dig_reg, ana_reg, hib_reg, slp_reg;
    int mismatches = 0, cmp_count = 0, cycles = 0;
    always #2 ref_clk = ~ref_clk;
    // short resume windows keep the run brief
    pmc_power_mode_controller #(.SLEEP_RESUME_CYC(10), .HIB_RESUME_CYC(20)) pmc_power_mode_controller_inst (
        .ref_clk(ref_clk), .srst(srst), .req_done(req_done), .req_valid_code(req_valid_code), .req_mode(req_mode),
        .active_template(act_t), .alt_template(alt_t), .ext_regulation(ext_regulation), .irq_any(irq_any),
        .wake_src(wake_src), .mode(mode), .resuming(resuming), .sub_enable(sub_enable), .cpu_enable(cpu_en),
        .sys_clk_enable(sys_clk), .low_speed_oscillator_enable(lo_osc), .khz_crystal_oscillator_enable(khz_osc),
        .sleep_timer_enable(slp_tmr), .dig_reg_enable(dig_reg), .ana_reg_enable(ana_reg), .hib_reg_enable(hib_reg),
        .sleep_reg_enable(slp_reg));
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict
    // a hang ends as a mismatch
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic req(input logic [1:0] m, input logic v);
        @(negedge ref_clk);
        req_done = 1'b1;
        req_valid_code = v;
        req_mode = m;
        @(negedge ref_clk);
        req_done = 1'b0;
        repeat (3) @(negedge ref_clk);
    endtask : req
    // holds the wake until the window opens, then measures its length
    task automatic wake(input logic [5:0] w, input int n);
        int k;
        @(negedge ref_clk);
        wake_src = w;
        k = 0;
        while (resuming !== 1'b1 && k < 8) begin
            @(negedge ref_clk);
            k++;
        end
        wake_src = 6'h0;
        k = 0;
        while (resuming === 1'b1 && k < 100) begin
            @(negedge ref_clk);
            k++;
        end
        chk(k[7:0], n[7:0]);
        repeat (2) @(negedge ref_clk);
        chk({6'h0, mode}, {6'h0, PMC_ACTIVE});
        chk({7'h0, cpu_en}, 8'h01);
    endtask : wake
    task automatic t_modes();
        chk(sub_enable, act_t | 8'h01);
        req(2'h1, 1'b1);
        chk({6'h0, mode}, {6'h0, PMC_ALT});
        chk(sub_enable, alt_t);
        req(2'h2, 1'b1);
        chk({2'h0, lo_osc, khz_osc, sub_enable[0], sys_clk, slp_reg, slp_tmr}, 8'h33);
        req(2'h3, 1'b1);
        chk({4'h0, hib_reg, dig_reg, ana_reg, lo_osc}, 8'h08);
        req(2'h0, 1'b1);
        chk(sub_enable, act_t);
        req(2'h2, 1'b0);
        chk({6'h0, mode}, {6'h0, PMC_ACTIVE});
    endtask : t_modes
    task automatic t_sleep_wake();
        for (int i = 0; i < 6; i++) begin
            req(2'h2, 1'b1);
            repeat (20) @(negedge ref_clk);
            wake(6'h01 << i, 10);
        end
    endtask : t_sleep_wake
    task automatic t_hib_irq();
        req(2'h3, 1'b1);
        wake_src = 6'h3d;
        irq_any = 1'b1;
        repeat (6) @(negedge ref_clk);
        wake_src = 6'h0;
        irq_any = 1'b0;
        chk({6'h0, mode}, {6'h0, PMC_HIB});
        wake(6'h02, 20);
        req(2'h1, 1'b1);
        irq_any = 1'b1;
        repeat (5) @(negedge ref_clk);
        irq_any = 1'b0;
        chk({6'h0, mode}, {6'h0, PMC_ACTIVE});
        repeat (30) @(negedge ref_clk);
    endtask : t_hib_irq
    task automatic t_ext();
        ext_regulation = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk({6'h0, dig_reg, ana_reg}, 8'h00);
        req(2'h2, 1'b1);
        wake(6'h08, 10);
        ext_regulation = 1'b0;
    endtask : t_ext
    // reset in mid-sleep must bring back active with the cpu forced on
    task automatic t_reset();
        req(2'h2, 1'b1);
        srst = 1'b1;
        repeat (3) @(negedge ref_clk);
        srst = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk({6'h0, mode}, {6'h0, PMC_ACTIVE});
        chk(sub_enable, act_t | 8'h01);
        chk({6'h0, sys_clk, slp_reg}, 8'h02);
        chk({7'h0, resuming}, 8'h00);
    endtask : t_reset
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(negedge ref_clk);
        srst = 1'b0;
        repeat (3) @(negedge ref_clk);
        t_modes();
        t_sleep_wake();
        t_hib_irq();
        t_ext();
        t_reset();
        give_verdict();
    end
endmodule : pmc_power_mode_controller_tb_top

bind pmc_power_mode_controller pmc_power_mode_controller_asserts #(.SUB_NUM(SUB_NUM),
    .SLEEP_RESUME_CYC(SLEEP_RESUME_CYC), .HIB_RESUME_CYC(HIB_RESUME_CYC)) pmc_power_mode_controller_asserts_inst (
    .ref_clk(ref_clk), .srst(srst), .req_done(req_done), .req_valid_code(req_valid_code), .req_mode(req_mode),
    .ext_regulation(ext_regulation), .irq_any(irq_any), .wake_src(wake_src), .mode(mode), .resuming(resuming),
    .sub_enable(sub_enable), .sys_clk_enable(sys_clk_enable), .low_speed_oscillator_enable(low_speed_oscillator_enable),
    .khz_crystal_oscillator_enable(khz_crystal_oscillator_enable), .sleep_timer_enable(sleep_timer_enable),
    .dig_reg_enable(dig_reg_enable), .ana_reg_enable(ana_reg_enable), .hib_reg_enable(hib_reg_enable));
